/* src/pcp_top.sv */
// port 1 and port 3 pin control with AHB-Lite register access
// Function
// - port 1 lines are all inputs after power-on reset
// - one configuration bit selects port 1 push-pull or open-drain drive
// - driver-style bit one gives push-pull, zero gives open-drain
// - stop-mode recovery returns every port 1 line to input
// - analog mode sends port 3 lines 1 and 2 to comparator front ends
// - analog mode takes comparator references from line 3 and ref pin
// - analog mode diverts line 3 latch and interrupt to stop recovery
// - digital mode shows line 3 as input bit 3 and raises interrupt one
// - stop mode powers comparators down; software keeps sources digital
// - comparator results can leave on port 3 lines 4 and 7
// - configuration bit 0 one drives comparator outputs, zero normal port
// - port 3 outputs can carry each timer output and the AND/OR logic
// - timer output selection follows common, 8-bit and 16-bit controls
`timescale 1ns/100ps
module pcp_top
  import pcp_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [DATA_W-1:0]    hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [DATA_W-1:0]    hrdata,
  output logic                      irq,
  input  wire logic [7:0]           port1_in,
  output logic      [7:0]           port1_out,
  output logic      [7:0]           port1_oe,
  input  wire logic [P3_IN_W-1:0]   port3_in,
  output logic      [P3_OUT_W-1:0]  port3_out,
  input  wire logic                 comparator_ref_pin,
  input  wire logic [1:0]           comparator_result,
  output logic                      comparator_power,
  output logic                      comparator_analog,
  input  wire logic [1:0]           timer_common_ctrl,
  input  wire logic                 timer8_ctrl,
  input  wire logic                 timer16_ctrl,
  input  wire logic                 eight_bit_timer,
  input  wire logic                 sixteen_bit_timer,
  input  wire logic                 and_or_out,
  input  wire logic                 stop_mode,
  input  wire logic                 stop_recovery,
  output logic      [2:0]           stop_recovery_src,
  output logic                      stop_recovery_alt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pcp_bus_e             bus_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic                 mapped_reg;
  logic                 write_reg;
  logic                 bus_req;
  logic                 wr_en;
  logic [DATA_W-1:0]    rd_next;

  logic [CFG_W-1:0]     port_config_reg;
  logic [7:0]           p1_dir_reg;
  logic [7:0]           p1_data_reg;
  logic                 p3_mode_reg;
  logic [P3_OUT_W-1:0]  p3_data_reg;
  logic [IRQ_W-1:0]     irq_mask_reg;

  logic [7:0]           p1_sync;
  logic [P3_IN_W-1:0]   p3_sync;
  logic [1:0]           cmp_sync;
  logic                 analog;
  logic [7:0]           p3_in_val;

  logic                 src1_prev_reg;
  logic                 src2_prev_reg;
  logic                 src3_prev_reg;
  logic                 src1;
  logic                 src2;
  logic [IRQ_W-1:0]     irq_evt;
  logic [IRQ_W-1:0]     irq_clr;
  logic [IRQ_W-1:0]     irq_status;

  logic [P3_OUT_W-1:0]  p3_out_next;
  pcp_tsel_e            line6_sel;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  pcp_sync #(
    .W   (8),
    .RST (8'h00)
  ) u_sync_p1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (port1_in),
    .q       (p1_sync)
  );

  pcp_sync #(
    .W   (P3_IN_W),
    .RST (4'h0)
  ) u_sync_p3 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({port3_in[3:1], comparator_ref_pin}),
    .q       (p3_sync)
  );

  pcp_sync #(
    .W   (2),
    .RST (2'h0)
  ) u_sync_cmp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (comparator_result),
    .q       (cmp_sync)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state on every transfer
  // ----------------------------------------------------------------
  assign bus_req = hsel & htrans[HTRANS_ACT_BIT] & hready;
  assign wr_en   = (bus_reg == BUS_ACCESS) & write_reg & mapped_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg    <= BUS_IDLE;
      addr_reg   <= '0;
      mapped_reg <= 1'b0;
      write_reg  <= 1'b0;
      hreadyout  <= 1'b1;
    end else begin
      unique case (bus_reg)
        BUS_IDLE: begin
          if (bus_req) begin
            addr_reg   <= haddr[ADDR_W-1:0];
            mapped_reg <= (haddr[31:ADDR_W] == '0);
            write_reg  <= hwrite;
            hreadyout  <= 1'b0;
            bus_reg    <= BUS_ACCESS;
          end
        end
        BUS_ACCESS: begin
          hreadyout <= 1'b1;
          bus_reg   <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (bus_reg == BUS_ACCESS && !write_reg) begin
      hrdata <= mapped_reg ? rd_next : '0;
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = '0;
    case (addr_reg)
      OFS_PORT_CFG: rd_next[CFG_W-1:0]    = port_config_reg;
      OFS_P1_DIR:   rd_next[7:0]          = p1_dir_reg;
      OFS_P1_DATA:  rd_next[7:0]          = p1_data_reg;
      OFS_P1_IN:    rd_next[7:0]          = p1_sync;
      OFS_P3_MODE:  rd_next[MODE_ANALOG_BIT] = p3_mode_reg;
      OFS_P3_DATA:  rd_next[7:P3_OUT_LSB] = p3_data_reg;
      OFS_P3_IN:    rd_next[7:0]          = p3_in_val;
      OFS_IRQ_STAT: rd_next[IRQ_W-1:0]    = irq_status;
      OFS_IRQ_MASK: rd_next[IRQ_W-1:0]    = irq_mask_reg;
      default:      rd_next               = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_config_reg <= PORT_CFG_RST;
    end else if (wr_en && addr_reg == OFS_PORT_CFG) begin
      port_config_reg <= hwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_dir_reg <= P1_DIR_RST;
    end else if (stop_recovery) begin
      p1_dir_reg <= P1_DIR_RST;
    end else if (wr_en && addr_reg == OFS_P1_DIR) begin
      p1_dir_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_data_reg <= P1_DATA_RST;
    end else if (wr_en && addr_reg == OFS_P1_DATA) begin
      p1_data_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p3_mode_reg <= 1'b0;
    end else if (wr_en && addr_reg == OFS_P3_MODE) begin
      p3_mode_reg <= hwdata[MODE_ANALOG_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p3_data_reg <= P3_DATA_RST;
    end else if (wr_en && addr_reg == OFS_P3_DATA) begin
      p3_data_reg <= hwdata[7:P3_OUT_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_en && addr_reg == OFS_IRQ_MASK) begin
      irq_mask_reg <= hwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // port 3 input view
  // ----------------------------------------------------------------
  assign analog = p3_mode_reg;

  always_comb begin
    p3_in_val    = '0;
    p3_in_val[0] = p3_sync[0];
    if (analog) begin
      p3_in_val[2:1] = cmp_sync;
    end else begin
      p3_in_val[3:1] = p3_sync[3:1];
    end
    p3_in_val[7:P3_OUT_LSB] = port3_out;
  end

  // ----------------------------------------------------------------
  // interrupt sources: falling edges of the selected levels
  // ----------------------------------------------------------------
  assign src1 = analog ? cmp_sync[0] : p3_sync[1];
  assign src2 = analog ? cmp_sync[1] : p3_sync[2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src1_prev_reg <= 1'b0;
      src2_prev_reg <= 1'b0;
      src3_prev_reg <= 1'b0;
    end else begin
      src1_prev_reg <= src1;
      src2_prev_reg <= src2;
      src3_prev_reg <= p3_sync[3];
    end
  end

  always_comb begin
    irq_evt              = '0;
    irq_evt[IRQ_TWO_BIT] = src1_prev_reg & ~src1;
    irq_evt[IRQ_ZERO_BIT] = src2_prev_reg & ~src2;
    // line 3 raises interrupt one only in digital mode
    irq_evt[IRQ_ONE_BIT] = ~analog & src3_prev_reg & ~p3_sync[3];
  end

  assign irq_clr = (wr_en && addr_reg == OFS_IRQ_STAT)
                   ? hwdata[IRQ_W-1:0] : '0;

  pcp_irq #(
    .W (IRQ_W)
  ) u_irq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .evt     (irq_evt),
    .clr     (irq_clr),
    .mask    (irq_mask_reg),
    .status  (irq_status),
    .irq     (irq)
  );

  // ----------------------------------------------------------------
  // comparator control and stop-mode recovery sources
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comparator_power  <= 1'b0;
      comparator_analog <= 1'b0;
    end else begin
      comparator_power  <= analog & ~stop_mode;
      comparator_analog <= analog;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_recovery_src <= '0;
      stop_recovery_alt <= 1'b0;
    end else begin
      stop_recovery_src <= analog ? 3'h0 : p3_sync[3:1];
      stop_recovery_alt <= analog & p3_sync[3];
    end
  end

  // ----------------------------------------------------------------
  // port 1 drivers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port1_out <= '0;
      port1_oe  <= '0;
    end else begin
      port1_out <= p1_data_reg;
      if (port_config_reg[CFG_PUSHPULL_BIT]) begin
        port1_oe <= p1_dir_reg;
      end else begin
        port1_oe <= p1_dir_reg & ~p1_data_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // port 3 output selection
  // ----------------------------------------------------------------
  assign line6_sel = pcp_tsel_e'(timer_common_ctrl);

  always_comb begin
    p3_out_next = p3_data_reg;
    if (port_config_reg[CFG_CMP_OUT_BIT]) begin
      p3_out_next[0] = cmp_sync[0];
    end else if (timer8_ctrl) begin
      p3_out_next[0] = eight_bit_timer;
    end
    if (timer16_ctrl) begin
      p3_out_next[1] = sixteen_bit_timer;
    end
    unique case (line6_sel)
      TSEL_PORT:  p3_out_next[2] = p3_data_reg[2];
      TSEL_T8:    p3_out_next[2] = eight_bit_timer;
      TSEL_T16:   p3_out_next[2] = sixteen_bit_timer;
      TSEL_LOGIC: p3_out_next[2] = and_or_out;
    endcase
    if (port_config_reg[CFG_CMP_OUT_BIT]) begin
      p3_out_next[3] = cmp_sync[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port3_out <= P3_DATA_RST;
    end else begin
      port3_out <= p3_out_next;
    end
  end

endmodule

/* include/pcp_pkg.sv */
// shared constants for the port 1 / port 3 pin control block
package pcp_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          HTRANS_ACT_BIT  = 1;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_PORT_CFG    = 8'h00;
  localparam logic [7:0]  OFS_P1_DIR      = 8'h04;
  localparam logic [7:0]  OFS_P1_DATA     = 8'h08;
  localparam logic [7:0]  OFS_P1_IN       = 8'h0C;
  localparam logic [7:0]  OFS_P3_MODE     = 8'h10;
  localparam logic [7:0]  OFS_P3_DATA     = 8'h14;
  localparam logic [7:0]  OFS_P3_IN       = 8'h18;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          CFG_CMP_OUT_BIT = 0;
  localparam int          CFG_PUSHPULL_BIT = 1;
  localparam int          CFG_W           = 2;
  localparam int          MODE_ANALOG_BIT = 0;
  localparam int          IRQ_ZERO_BIT    = 0;
  localparam int          IRQ_ONE_BIT     = 1;
  localparam int          IRQ_TWO_BIT     = 2;
  localparam int          IRQ_W           = 3;
  localparam int          P3_IN_W         = 4;
  localparam int          P3_OUT_W        = 4;
  localparam int          P3_OUT_LSB      = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  PORT_CFG_RST    = 2'h0;
  localparam logic [7:0]  P1_DIR_RST      = 8'h00;
  localparam logic [7:0]  P1_DATA_RST     = 8'h00;
  localparam logic [3:0]  P3_DATA_RST     = 4'h0;
  localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSEL_PORT  = 2'h0,
    TSEL_T8    = 2'h1,
    TSEL_T16   = 2'h2,
    TSEL_LOGIC = 2'h3
  } pcp_tsel_e;

  typedef enum logic {BUS_IDLE, BUS_ACCESS} pcp_bus_e;

endpackage

/* src/pcp_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pcp_sync #(
  parameter int W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  if (W < 1) $error("pcp_sync width must be positive");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      q      <= RST;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a bit changes only once two late stages agree
      q      <= (q & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
    end
  end

endmodule

/* src/pcp_irq.sv */
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/100ps
module pcp_irq #(
  parameter int W = 3
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] mask,
  output logic      [W-1:0] status,
  output logic              irq
);

  logic [W-1:0] status_next;

  if (W < 1) $error("pcp_irq width must be positive");

  // a new event wins over a clear in the same cycle
  always_comb begin
    status_next = (status & ~clr) | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= status_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask);
    end
  end

endmodule

/* test/pcp_top_assertions.sv */
// concurrent checks on the pin control block ports
`timescale 1ns/100ps
module pcp_top_assertions (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic [7:0] port1_oe,
  input wire logic [3:0] port3_out,
  input wire logic       stop_mode,
  input wire logic       stop_recovery,
  input wire logic       comparator_power,
  input wire logic       comparator_analog,
  input wire logic [2:0] stop_recovery_src,
  input wire logic       stop_recovery_alt,
  input wire logic [1:0] timer_common_ctrl,
  input wire logic       timer16_ctrl,
  input wire logic       sixteen_bit_timer,
  input wire logic       and_or_out
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  a_taken_waits: assert property (
    hsel && htrans[1] && hready && hreadyout |=> !hreadyout)
    else $error("transfer taken without a wait state");
  a_single_wait: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");

  // ----------------------------------------------------------------
  // pins, comparators and timer routing
  // ----------------------------------------------------------------
  a_recov_p1_input: assert property (
    stop_recovery |-> ##2 port1_oe == 8'h00)
    else $error("port 1 still driving after recovery");
  a_stop_power_down: assert property (
    stop_mode |=> !comparator_power)
    else $error("comparators powered in stop");
  a_power_needs_analog: assert property (
    comparator_power |-> comparator_analog)
    else $error("comparators powered in digital mode");
  a_analog_src_off: assert property (
    comparator_analog |-> stop_recovery_src == 3'h0)
    else $error("recovery sources live in analog mode");
  a_alt_digital_off: assert property (
    !comparator_analog |-> !stop_recovery_alt)
    else $error("line 3 diverted in digital mode");
  a_line5_timer: assert property (
    timer16_ctrl |=> port3_out[1] == $past(sixteen_bit_timer))
    else $error("line 5 not following 16-bit timer");
  a_line6_logic: assert property (
    timer_common_ctrl == 2'h3 |=> port3_out[2] == $past(and_or_out))
    else $error("line 6 not following and/or logic");

  c_recovery: cover property (stop_recovery);
  c_powered: cover property (comparator_power);
  c_logic_out: cover property (timer_common_ctrl == 2'h3 ##1 port3_out[2]);
endmodule

/* test/pcp_pins_model.sv */
// board pins with pull-ups and behavioural comparators
`timescale 1ns/100ps
module pcp_pins_model (
  input  wire logic [7:0] port1_out,
  input  wire logic [7:0] port1_oe,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [3:0] port3_in,
  input  wire logic       comparator_ref_pin,
  input  wire logic       comparator_power,
  output logic      [7:0] port1_pins,
  output logic      [1:0] comparator_result
);
  // undriven port 1 lines fall to the board pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port1_pins[i] = port1_oe[i] ? port1_out[i] :
                      ext_en[i] ? ext_val[i] : 1'b1;
    end
  end

  // each comparator trips while its input sits above its reference
  always_comb begin
    comparator_result = 2'h0;
    if (comparator_power) begin
      comparator_result[0] = port3_in[1] & ~comparator_ref_pin;
      comparator_result[1] = port3_in[2] & ~port3_in[3];
    end
  end
endmodule

/* test/test_pcp_top.sv */
// self-checking bench for the pin control block
`timescale 1ns/100ps
module test_pcp_top
  import pcp_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, timer_common_ctrl, comparator_result;
  logic [2:0]  hsize, stop_recovery_src;
  logic [7:0]  port1_in, port1_out, port1_oe, ext_en, ext_val;
  logic [3:0]  port3_in, port3_out;
  logic        comparator_ref_pin, comparator_power, comparator_analog;
  logic        timer8_ctrl, timer16_ctrl, eight_bit_timer;
  logic        sixteen_bit_timer, and_or_out, stop_mode, stop_recovery;
  logic        stop_recovery_alt;
  int          miscompares, tests_run, cycles;

  pcp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .port1_in(port1_in),
    .port1_out(port1_out), .port1_oe(port1_oe), .port3_in(port3_in),
    .port3_out(port3_out), .comparator_ref_pin(comparator_ref_pin),
    .comparator_result(comparator_result),
    .comparator_power(comparator_power),
    .comparator_analog(comparator_analog),
    .timer_common_ctrl(timer_common_ctrl), .timer8_ctrl(timer8_ctrl),
    .timer16_ctrl(timer16_ctrl), .eight_bit_timer(eight_bit_timer),
    .sixteen_bit_timer(sixteen_bit_timer), .and_or_out(and_or_out),
    .stop_mode(stop_mode), .stop_recovery(stop_recovery),
    .stop_recovery_src(stop_recovery_src),
    .stop_recovery_alt(stop_recovery_alt));

  pcp_pins_model pins (.port1_out(port1_out), .port1_oe(port1_oe),
    .ext_en(ext_en), .ext_val(ext_val), .port3_in(port3_in),
    .comparator_ref_pin(comparator_ref_pin),
    .comparator_power(comparator_power), .port1_pins(port1_in),
    .comparator_result(comparator_result));

  always #10 hclk = ~hclk;

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(n, e, x);
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("port1_oe", 32'h0, 32'(port1_oe));
    rd_chk("p1_dir", OFS_P1_DIR, 32'h0);
    chk("port3_out", 32'h0, 32'(port3_out));
  endtask

  task automatic t_drive();
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    wr(OFS_P1_DIR, 32'hFF);
    wr(OFS_P1_DATA, 32'hA5);
    wr(OFS_PORT_CFG, 32'h2);
    settle(1);
    chk("oe push-pull", 32'hFF, 32'(port1_oe));
    chk("port1_out", 32'hA5, 32'(port1_out));
    settle(6);
    rd_chk("p1_in push-pull", OFS_P1_IN, 32'hA5);
    wr(OFS_PORT_CFG, 32'h0);
    settle(1);
    chk("oe open-drain", 32'h5A, 32'(port1_oe));
    settle(6);
    rd_chk("p1_in open-drain", OFS_P1_IN, 32'h00);
  endtask

  task automatic t_recover();
    stop_recovery <= 1'b1;
    @(posedge hclk);
    stop_recovery <= 1'b0;
    settle(2);
    chk("oe after recovery", 32'h0, 32'(port1_oe));
    rd_chk("dir after recovery", OFS_P1_DIR, 32'h0);
  endtask

  task automatic t_analog();
    port3_in <= 4'hA;
    wr(OFS_P3_MODE, 32'h1);
    settle(1);
    chk("analog", 32'h1, 32'(comparator_analog));
    chk("power", 32'h1, 32'(comparator_power));
    settle(6);
    rd_chk("p3_in analog", OFS_P3_IN, 32'h2);
    chk("alt", 32'h1, 32'(stop_recovery_alt));
    chk("src analog", 32'h0, 32'(stop_recovery_src));
    wr(OFS_IRQ_STAT, 32'h7);
    port3_in <= 4'h2;
    settle(6);
    rd_chk("stat analog", OFS_IRQ_STAT, 32'h0);
    stop_mode <= 1'b1;
    settle(2);
    chk("power in stop", 32'h0, 32'(comparator_power));
    stop_mode <= 1'b0;
  endtask

  task automatic t_digital();
    wr(OFS_P3_MODE, 32'h0);
    port3_in <= 4'h8;
    settle(6);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h2);
    rd_chk("p3_in digital", OFS_P3_IN, 32'h8);
    chk("src digital", 32'h4, 32'(stop_recovery_src));
    port3_in <= 4'h0;
    settle(6);
    rd_chk("stat line3", OFS_IRQ_STAT, 32'h2);
    chk("irq set", 32'h1, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h0);
    settle(2);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h2);
    rd_chk("stat cleared", OFS_IRQ_STAT, 32'h0);
  endtask

  task automatic t_cmpout();
    port3_in <= 4'hA;
    wr(OFS_P3_MODE, 32'h1);
    wr(OFS_P3_DATA, 32'h80);
    wr(OFS_PORT_CFG, 32'h1);
    settle(6);
    chk("cmp on lines", 32'h1, 32'(port3_out));
    wr(OFS_PORT_CFG, 32'h0);
    settle(1);
    chk("lines released", 32'h8, 32'(port3_out));
    comparator_ref_pin <= 1'b1;
    settle(6);
    rd_chk("p3_in ref", OFS_P3_IN, 32'h81);
  endtask

  task automatic t_timers();
    logic [3:0] e;
    wr(OFS_P3_DATA, 32'h0);
    timer8_ctrl <= 1'b1;
    timer16_ctrl <= 1'b1;
    and_or_out <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        eight_bit_timer <= (p == 0);
        sixteen_bit_timer <= (p == 1);
        timer_common_ctrl <= 2'(c);
        e = {1'b0, 1'b0, (p == 1), (p == 0)};
        e[2] = (c == 1) ? (p == 0) : (c == 2) ? (p == 1) : (c == 3);
        settle(2);
        chk("timer lines", 32'(e), 32'(port3_out));
      end
    end
    rd_chk("unmapped", 8'h24, 32'h0);
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, stop_mode, stop_recovery} = '0;
    {timer8_ctrl, timer16_ctrl, eight_bit_timer} = '0;
    {sixteen_bit_timer, and_or_out, comparator_ref_pin} = '0;
    {haddr, hwdata, htrans, timer_common_ctrl} = '0;
    {ext_en, ext_val, port3_in} = '0;
    hsize = 3'h2;
    {miscompares, tests_run, cycles} = '0;
    settle(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_drive();
    t_recover();
    t_analog();
    t_digital();
    t_cmpout();
    t_timers();
    final_report();
  end
endmodule

bind pcp_top pcp_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .port1_oe(port1_oe), .port3_out(port3_out), .stop_mode(stop_mode),
  .stop_recovery(stop_recovery), .comparator_power(comparator_power),
  .comparator_analog(comparator_analog),
  .stop_recovery_src(stop_recovery_src),
  .stop_recovery_alt(stop_recovery_alt),
  .timer_common_ctrl(timer_common_ctrl), .timer16_ctrl(timer16_ctrl),
  .sixteen_bit_timer(sixteen_bit_timer), .and_or_out(and_or_out));
